// *** design/clk_ctrl_pkg.sv ***
// package: control register layout, reset values and structs for the clock interlock
package clk_ctrl_pkg;
	// ****************************************
	// control register field positions
	// ****************************************
	localparam int BIT_MON_IRQ_EN = 7;
	localparam int BIT_MON_FLAG = 6;
	localparam int BIT_MON_ON = 5;
	localparam int BIT_SEL_EXT = 4;
	localparam int BIT_INT_ON = 3;
	localparam int BIT_INT_STABLE = 2;
	localparam int BIT_EXT_ON = 1;
	localparam int BIT_EXT_STABLE = 0;
	localparam int CTRL_W = 8;
	// ****************************************
	// reset values and synchroniser stage count
	// ****************************************
	localparam logic [7:0] CTRL_RESET = 8'h08;
	localparam int SYNC_STAGES = 3;

	// status coming from the clock generators and monitor
	typedef struct packed {
		logic int_clock_stable;
		logic ext_clock_stable;
		logic int_inactive;
		logic ext_inactive;
	} gen_status_t;

	// software write port
	typedef struct packed {
		logic wr;
		logic [7:0] data;
	} ctrl_write_t;
endpackage

// *** design/clock_switch_monitor_interlock.sv ***
// clock control register with source-switch and monitor-enable interlocks
// ****************************************
// ****************************************
`timescale 1ns/100ps
module clock_switch_monitor_interlock (
	input wire logic sys_clk_i, // 100 MHz system clock
	input wire logic rst_i, // synchronous reset, active high
	input clk_ctrl_pkg::ctrl_write_t ctrl_wr_i, // software write strobe and data
	input clk_ctrl_pkg::gen_status_t gen_status_i, // asynchronous generator status
	output logic [7:0] ctrl_rd_o, // control register read-back
	output logic sel_ext_o, // clock switch select, high = external
	output logic int_clock_on_o, // internal generator enable
	output logic ext_clock_on_o, // external generator enable
	output logic monitor_on_o, // clock monitor enable
	output logic monitor_irq_o // monitor interrupt request level
);
	import clk_ctrl_pkg::*;

	logic int_stable;
	logic ext_stable;
	logic int_off;
	logic ext_off;
	logic sel_ext;
	logic int_on;
	logic ext_on;
	logic mon_on;
	logic mon_irq_en;
	logic mon_flag;
	logic next_sel_ext;
	logic next_int_on;
	logic next_ext_on;
	logic next_mon_on;
	logic next_mon_irq_en;
	logic mon_trip;
	logic [7:0] wd;

	// ****************************************
	// status synchronisers
	// ****************************************
	// internal generator stable flag
	level_sync u_sync_is (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(gen_status_i.int_clock_stable),
		.level_o(int_stable)
	);
	// external generator stable flag
	level_sync u_sync_es (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(gen_status_i.ext_clock_stable),
		.level_o(ext_stable)
	);
	// internal clock inactivity from the monitor
	level_sync u_sync_io (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(gen_status_i.int_inactive),
		.level_o(int_off)
	);
	// external clock inactivity from the monitor
	level_sync u_sync_eo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(gen_status_i.ext_inactive),
		.level_o(ext_off)
	);

	// ****************************************
	// helper functions
	// ****************************************
	// a generator counts as ready when it is both on and stable
	function automatic logic gen_ready(input logic on, input logic stable);
		return on && stable;
	endfunction
	// a switch needs the current source on and the target on and stable
	function automatic logic switch_ok(input logic cur_on, input logic tgt_on,
		input logic tgt_stable);
		return cur_on && gen_ready(tgt_on, tgt_stable);
	endfunction

	assign wd = ctrl_wr_i.data;
	// monitor sees a dead source only while on with both generators on
	assign mon_trip = mon_on && int_on && ext_on && (int_off || ext_off);

	// ****************************************
	// interlocked next values
	// ****************************************
	// select follows a write only when the switch interlock allows it
	always_comb begin
		next_sel_ext = sel_ext;
		if (ctrl_wr_i.wr && wd[BIT_SEL_EXT] && !sel_ext) begin
			if (switch_ok(int_on, ext_on, ext_stable)) begin
				next_sel_ext = 1'b1;
			end
		end else if (ctrl_wr_i.wr && !wd[BIT_SEL_EXT] && sel_ext) begin
			if (switch_ok(ext_on, int_on, int_stable)) begin
				next_sel_ext = 1'b0;
			end
		end
	end

	// internal on clears only once select already sits on external and stays
	always_comb begin
		next_int_on = int_on;
		if (ctrl_wr_i.wr) begin
			if (wd[BIT_INT_ON]) begin
				next_int_on = 1'b1;
			end else if (sel_ext && next_sel_ext && !mon_trip) begin
				next_int_on = 1'b0;
			end
		end
	end

	// external on clears only once select already sits on internal and stays
	always_comb begin
		next_ext_on = ext_on;
		if (ctrl_wr_i.wr) begin
			if (wd[BIT_EXT_ON]) begin
				next_ext_on = 1'b1;
			end else if (!sel_ext && !next_sel_ext && !mon_trip) begin
				next_ext_on = 1'b0;
			end
		end
	end

	// monitor on needs both generators ready; irq enable needs monitor on
	always_comb begin
		next_mon_on = mon_on;
		next_mon_irq_en = mon_irq_en;
		if (ctrl_wr_i.wr) begin
			if (!wd[BIT_MON_ON]) begin
				next_mon_on = 1'b0;
			end else if (gen_ready(int_on, int_stable) && gen_ready(ext_on, ext_stable)) begin
				next_mon_on = 1'b1;
			end
			if (!wd[BIT_MON_IRQ_EN]) begin
				next_mon_irq_en = 1'b0;
			end else if (mon_on) begin
				next_mon_irq_en = 1'b1;
			end
		end
	end

	// ****************************************
	// clock select, forced on monitor trip
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sel_ext <= CTRL_RESET[BIT_SEL_EXT];
		end else if (mon_trip) begin
			sel_ext <= !ext_off;
		end else begin
			sel_ext <= next_sel_ext;
		end
	end

	// generator enables and monitor controls
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			int_on <= CTRL_RESET[BIT_INT_ON];
			ext_on <= CTRL_RESET[BIT_EXT_ON];
			mon_on <= CTRL_RESET[BIT_MON_ON];
			mon_irq_en <= CTRL_RESET[BIT_MON_IRQ_EN];
		end else begin
			int_on <= next_int_on;
			ext_on <= next_ext_on;
			mon_on <= next_mon_on;
			mon_irq_en <= next_mon_irq_en;
		end
	end

	// sticky monitor flag; write 0 clears, trip wins over clear
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mon_flag <= CTRL_RESET[BIT_MON_FLAG];
		end else if (mon_trip) begin
			mon_flag <= 1'b1;
		end else if (ctrl_wr_i.wr && !wd[BIT_MON_FLAG]) begin
			mon_flag <= 1'b0;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl_rd_o <= CTRL_RESET;
			sel_ext_o <= CTRL_RESET[BIT_SEL_EXT];
			int_clock_on_o <= CTRL_RESET[BIT_INT_ON];
			ext_clock_on_o <= CTRL_RESET[BIT_EXT_ON];
			monitor_on_o <= CTRL_RESET[BIT_MON_ON];
			monitor_irq_o <= CTRL_RESET[BIT_MON_FLAG] & CTRL_RESET[BIT_MON_IRQ_EN];
		end else begin
			// read-back layout
			ctrl_rd_o <= {mon_irq_en, mon_flag, mon_on, sel_ext,
				int_on, int_stable & int_on, ext_on, ext_stable & ext_on};
			sel_ext_o <= sel_ext;
			int_clock_on_o <= int_on;
			ext_clock_on_o <= ext_on;
			monitor_on_o <= mon_on && int_on && ext_on;
			monitor_irq_o <= mon_flag && mon_irq_en;
		end
	end
endmodule // clock_switch_monitor_interlock

// *** design/level_sync.sv ***
// three-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
module level_sync (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic async_i, // asynchronous level
	output logic level_o // filtered level
);
	import clk_ctrl_pkg::*;
	logic meta;
	logic s2;
	logic s3;
	// ****************************************
	// capture chain
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			meta <= async_i;
			s2 <= meta;
			s3 <= s2;
		end
	end
	// change accepted once stages two and three agree
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			level_o <= 1'b0;
		end else if (s2 == s3) begin
			level_o <= s3;
		end
	end
endmodule // level_sync

// *** tb/clock_switch_monitor_interlock_checker.sv ***
// checker: interlock assertions for the clock control block
`timescale 1ns/100ps
module clock_switch_monitor_interlock_checker (
	input wire logic sys_clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic [7:0] ctrl_rd_o, // read-back
	input wire logic sel_ext_o, // select
	input wire logic int_clock_on_o, // internal on
	input wire logic ext_clock_on_o, // external on
	input wire logic monitor_on_o, // monitor on
	input wire logic monitor_irq_o // monitor irq
);
	import clk_ctrl_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// reset value and source switch interlocks
	a_reset_value: assert property ($past(rst_i) |-> ctrl_rd_o == CTRL_RESET)
		else $error("reset value wrong");
	a_sel_ext_gate: assert property ($rose(sel_ext_o) |-> int_clock_on_o && ext_clock_on_o)
		else $error("select moved to external without both on");
	a_sel_int_gate: assert property ($fell(sel_ext_o) |-> int_clock_on_o && ext_clock_on_o)
		else $error("select moved to internal without both on");
	a_int_stays_on: assert property (!sel_ext_o |-> int_clock_on_o)
		else $error("internal off while selected");
	a_ext_stays_on: assert property (sel_ext_o |-> ext_clock_on_o)
		else $error("external off while selected");
	// monitor interlocks and read-back mirror
	a_mon_needs_both: assert property (monitor_on_o |-> int_clock_on_o && ext_clock_on_o)
		else $error("monitor on without both generators");
	a_mon_out_match: assert property (monitor_on_o == (ctrl_rd_o[5] && ctrl_rd_o[3] && ctrl_rd_o[1]))
		else $error("monitor output not monitor on with both generators");
	a_mon_set_gate: assert property ($rose(ctrl_rd_o[5]) |-> $past(ctrl_rd_o[3:0]) == 4'hF)
		else $error("monitor on set without all on and stable");
	a_irq_en_gate: assert property ($rose(ctrl_rd_o[7]) |-> $past(ctrl_rd_o[5]))
		else $error("irq enable set while monitor off");
	a_irq_from_flag: assert property (monitor_irq_o == (ctrl_rd_o[7] && ctrl_rd_o[6]))
		else $error("irq not flag and enable");
	a_rd_mirror: assert property ({ctrl_rd_o[4:3], ctrl_rd_o[1]} == {sel_ext_o, int_clock_on_o, ext_clock_on_o})
		else $error("read-back does not match outputs");
	c_sel_ext: cover property ($rose(sel_ext_o));
	c_mon_on: cover property ($rose(monitor_on_o));
	c_irq: cover property (monitor_irq_o);
endmodule // clock_switch_monitor_interlock_checker
bind clock_switch_monitor_interlock clock_switch_monitor_interlock_checker chk_i (.sys_clk_i,
	.rst_i, .ctrl_rd_o, .sel_ext_o, .int_clock_on_o, .ext_clock_on_o, .monitor_on_o, .monitor_irq_o);

// *** tb/clock_switch_monitor_interlock_test.sv ***
// testbench: directed and random writes against the clock interlock
`timescale 1ns/100ps
module clock_switch_monitor_interlock_test;
	import clk_ctrl_pkg::*;
	logic sys_clk_i = 0, rst_i = 1, chk = 0, irq;
	ctrl_write_t wr = '0;
	gen_status_t st = '0;
	logic [7:0] rd;
	logic [8:0] q[$];
	logic [31:0] rs = 32'hCB39;
	int error_cnt = 0, checked = 0, cyc = 0;
	clock_switch_monitor_interlock clock_switch_monitor_interlock_i (.sys_clk_i, .rst_i,
		.ctrl_wr_i(wr), .gen_status_i(st), .ctrl_rd_o(rd), .sel_ext_o(), .int_clock_on_o(),
		.ext_clock_on_o(), .monitor_on_o(), .monitor_irq_o(irq));
	// clock
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic final_report();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [8:0] got, input logic [8:0] want);
		checked++;
		if (got !== want) begin
			error_cnt++;
			$display("ERROR %0t read-back %h expected %h", $time, got, want);
		end
	endtask
	// note an expected irq and read-back, flag it for the watcher
	task automatic look(input logic [8:0] e);
		q.push_back(e);
		chk <= 1'b1;
		@(posedge sys_clk_i);
		chk <= 1'b0;
	endtask
	// one write pulse, then wait for the read-back to settle
	task automatic put(input logic [7:0] d, input logic [8:0] e);
		wr <= '{1'b1, d};
		@(posedge sys_clk_i);
		wr.wr <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		look(e);
	endtask
	// watcher: oldest note against outputs
	always @(posedge sys_clk_i) begin
		if (chk) begin
			cmp({irq, rd}, q.pop_front());
		end
	end
	// hang guard
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			final_report();
		end
	end
	// main sequence
	initial begin
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		look({1'b0, CTRL_RESET});
		st <= 4'b1000;
		repeat (8) @(posedge sys_clk_i);
		put(8'h13, 9'h00E);
		st <= 4'b1100;
		repeat (8) @(posedge sys_clk_i);
		put(8'h13, 9'h01F);
		put(8'h13, 9'h013);
		put(8'h1B, 9'h01F);
		put(8'h0C, 9'h00F);
		put(8'h0C, 9'h00C);
		put(8'hAF, 9'h00F);
		put(8'hAF, 9'h02F);
		put(8'hAF, 9'h0AF);
		st <= 4'b0110;
		repeat (8) @(posedge sys_clk_i);
		look(9'h1FB);
		st <= 4'b1100;
		repeat (8) @(posedge sys_clk_i);
		put(8'hBF, 9'h0BF);
		put(8'hA2, 9'h0AF);
		put(8'hB8, 9'h0BF);
		$display("test directed done");
		for (int i = 0; i < 40; i++) begin
			rs = xs(rs);
			st <= rs[11:8];
			wr <= {1'b1, rs[7:0]};
			@(posedge sys_clk_i);
			wr.wr <= 1'b0;
			@(posedge sys_clk_i);
		end
		$display("test random done");
		final_report();
	end
endmodule // clock_switch_monitor_interlock_test
